// >>> rtl/ipc_ctrl.sv
// Interrupt acceptance and power mode control with an AHB-Lite slave.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
// ============================================================
module ipc_ctrl (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic hready,
  input logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input logic [6:0] src_req,
  input logic wdt_reset,
  input logic ext_mem,
  input logic t1_baud_src,
  input logic [1:0] uart_mode,
  input logic core_ack,
  input logic core_return_from_interrupt,
  output ipc_pkg::ipc_irq_t irq_o,
  output ipc_pkg::ipc_pins_t pins_o,
  output logic baud_x2
);
  import ipc_pkg::*;

  // ==========================================================
  // Declarations
  // ==========================================================
  logic wr_pend_r;
  logic rd_pend_r;
  logic [31:0] dp_addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic [7:0] ie_r;
  logic [6:0] ip_r;
  logic baud_doubler_r;
  logic [1:0] gf_r;
  ipc_mode_t mode_r;
  ipc_mode_t mode_nxt;
  ipc_irq_t irq_r;
  ipc_pins_t pins_r;
  ipc_pins_t pins_nxt;
  logic act_hi_r;
  logic act_lo_r;
  logic baud_x2_r;
  logic [7:0] rd_mux;
  logic hi_v;
  logic lo_v;
  logic [2:0] hi_num;
  logic [2:0] lo_num;

  // ==========================================================
  // Bus address phase decode
  // ==========================================================
  wire addr_ok = hsel && htrans[1] && hready;
  wire rd_start = addr_ok && !hwrite;
  wire wr_power_mode_control = wr_pend_r && (dp_addr_r == IPC_ADR_POWER_MODE_CONTROL);
  wire wr_ie = wr_pend_r && (dp_addr_r == IPC_ADR_IE);
  wire wr_ip = wr_pend_r && (dp_addr_r == IPC_ADR_IP);
  wire in_run = (mode_r == IPC_RUN);
  wire in_idle = (mode_r == IPC_IDLE);
  wire in_pdown = (mode_r == IPC_PDOWN);

  // Writes complete with no wait; reads take one wait state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      dp_addr_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
    end else if (hready) begin
      wr_pend_r <= addr_ok && hwrite;
      rd_pend_r <= rd_start;
      hreadyout_r <= !rd_start;
      if (addr_ok) begin
        dp_addr_r <= haddr;
      end
    end else begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      hreadyout_r <= 1'b1;
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================
  wire [7:0] power_mode_control_rd = {baud_doubler_r, 3'b000, gf_r, in_pdown, in_idle};
  wire [7:0] stat_rd = {irq_r.num, act_hi_r, act_lo_r, irq_r.valid,
                        in_pdown, in_idle};
  wire [7:0] pend_rd = {1'b0, src_req & ie_r[6:0]};

  assign rd_mux = (dp_addr_r == IPC_ADR_POWER_MODE_CONTROL) ? power_mode_control_rd :
                  (dp_addr_r == IPC_ADR_IE) ? ie_r :
                  (dp_addr_r == IPC_ADR_IP) ? {1'b0, ip_r} :
                  (dp_addr_r == IPC_ADR_STAT) ? stat_rd :
                  (dp_addr_r == IPC_ADR_PEND) ? pend_rd : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
      hresp_r <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
      if (rd_pend_r) begin
        hrdata_r <= {24'h000000, rd_mux};
      end
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;

  // ==========================================================
  // Enable, priority and power control registers
  // ==========================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ie_r <= IPC_IE_RST;
      ip_r <= IPC_IP_RST;
      baud_doubler_r <= IPC_BAUD_DOUBLER_RST;
      gf_r <= IPC_GF_RST;
    end else if (wdt_reset) begin
      ie_r <= IPC_IE_RST;
      ip_r <= IPC_IP_RST;
      baud_doubler_r <= IPC_BAUD_DOUBLER_RST;
      gf_r <= IPC_GF_RST;
    end else begin
      if (wr_ie) begin
        ie_r <= hwdata[7:0];
      end
      if (wr_ip) begin
        ip_r <= hwdata[6:0];
      end
      if (wr_power_mode_control) begin
        baud_doubler_r <= hwdata[IPC_POWER_MODE_CONTROL_BAUD_DOUBLER];
        gf_r <= hwdata[IPC_POWER_MODE_CONTROL_GF1:IPC_POWER_MODE_CONTROL_GF0];
      end
    end
  end

  // ==========================================================
  // Arbitration
  // ==========================================================
  wire gate = ie_r[IPC_IE_GATE];
  wire [6:0] wmask = in_pdown ? IPC_WAKE_MASK : 7'h7F;
  wire [6:0] elig = src_req & ie_r[6:0] & {7{gate}} & wmask;
  wire [6:0] elig_hi = elig & ip_r;
  wire [6:0] elig_lo = elig & ~ip_r;

  ipc_pick #(
    .N(IPC_NSRC)
  ) u_pick_hi (
    .req(elig_hi),
    .valid(hi_v),
    .num(hi_num)
  );

  ipc_pick #(
    .N(IPC_NSRC)
  ) u_pick_lo (
    .req(elig_lo),
    .valid(lo_v),
    .num(lo_num)
  );

  wire hi_ok = hi_v && !act_hi_r;
  wire lo_ok = lo_v && !act_hi_r && !act_lo_r;
  wire wake = hi_ok || lo_ok;
  wire accept = wake && !irq_r.valid;
  wire [2:0] sel_num = hi_ok ? hi_num : lo_num;

  // A raised request stands until the core vectors to it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= '0;
    end else if (wdt_reset) begin
      irq_r <= '0;
    end else if (accept) begin
      irq_r.valid <= 1'b1;
      irq_r.level <= hi_ok;
      irq_r.num <= sel_num;
      irq_r.vector <= IPC_VEC[sel_num];
    end else if (core_ack) begin
      irq_r.valid <= 1'b0;
    end
  end

  assign irq_o = irq_r;

  // Levels in service; a return ends the highest one first.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_hi_r <= 1'b0;
      act_lo_r <= 1'b0;
    end else if (wdt_reset) begin
      act_hi_r <= 1'b0;
      act_lo_r <= 1'b0;
    end else if (core_ack && irq_r.valid) begin
      if (irq_r.level) begin
        act_hi_r <= 1'b1;
      end else begin
        act_lo_r <= 1'b1;
      end
    end else if (core_return_from_interrupt) begin
      if (act_hi_r) begin
        act_hi_r <= 1'b0;
      end else begin
        act_lo_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Power mode sequencing
  // ==========================================================
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      IPC_RUN: begin
        if (wr_power_mode_control && hwdata[IPC_POWER_MODE_CONTROL_PD]) begin
          mode_nxt = IPC_PDOWN;
        end else if (wr_power_mode_control && hwdata[IPC_POWER_MODE_CONTROL_IDL]) begin
          mode_nxt = IPC_IDLE;
        end
      end
      IPC_IDLE: begin
        if (wake) begin
          mode_nxt = IPC_RUN;
        end
      end
      IPC_PDOWN: begin
        if (wake) begin
          mode_nxt = IPC_RUN;
        end
      end
      default: begin
        mode_nxt = IPC_RUN;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= IPC_RUN;
    end else if (wdt_reset) begin
      mode_r <= IPC_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ==========================================================
  // Pin control and baud doubling
  // ==========================================================
  assign pins_nxt.halt = !in_run;
  assign pins_nxt.osc_stop = in_pdown;
  assign pins_nxt.ale_force = !in_run;
  assign pins_nxt.ale_level = in_idle;
  assign pins_nxt.port0_float = !in_run && ext_mem;
  assign pins_nxt.port2_addr = in_idle && ext_mem;
  assign pins_nxt.port2_sfr = in_pdown && ext_mem;

  wire baud_nxt = baud_doubler_r && t1_baud_src && (uart_mode != 2'b00);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_r <= '0;
      baud_x2_r <= 1'b0;
    end else begin
      pins_r <= pins_nxt;
      baud_x2_r <= baud_nxt;
    end
  end

  assign pins_o = pins_r;
  assign baud_x2 = baud_x2_r;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_gate_closed: assert property (
    (!gate && !irq_r.valid && !wdt_reset) |=> !irq_r.valid
  ) else $error("Interrupt raised while the global gate was closed.");

  chk_enable_bit: assert property (
    accept |-> ie_r[IPC_ORDER_BIT[sel_num]] && src_req[IPC_ORDER_BIT[sel_num]]
  ) else $error("Interrupt accepted from a disabled source.");

  chk_fixed_order: assert property (
    (accept && !hi_ok && elig_lo[IPC_SRC_EXT0] && !wdt_reset)
      |=> irq_r.num == 3'h0 && irq_r.vector == 16'h0003
  ) else $error("External 0 did not win its level.");

  chk_high_level: assert property (
    (accept && hi_v && !act_hi_r && !wdt_reset) |=> irq_r.level
  ) else $error("High level request lost to a low level one.");

  chk_preempt_low: assert property (
    (act_hi_r && !irq_r.valid) |-> !accept
  ) else $error("Request accepted during a high level routine.");

  chk_idle_entry: assert property (
    (in_run && wr_power_mode_control && hwdata[1:0] == 2'b01 && !wdt_reset)
      |=> in_idle ##1 (pins_o.halt && pins_o.ale_level)
  ) else $error("Idle was not entered after the idle write.");

  chk_pd_wins: assert property (
    (in_run && wr_power_mode_control && hwdata[1:0] == 2'b11 && !wdt_reset)
      |=> in_pdown ##1 pins_o.osc_stop
  ) else $error("Power-down did not take precedence over idle.");

  chk_idle_wake: assert property (
    (in_idle && wake && !irq_r.valid && !wdt_reset)
      |=> in_run && irq_r.valid
  ) else $error("Enabled interrupt did not end idle.");

  chk_pd_wake: assert property (
    (in_pdown && !wake && !wdt_reset) |=> in_pdown
  ) else $error("Power-down ended without a wake source.");

  chk_pd_pins: assert property (
    (in_pdown && !wdt_reset) |=> pins_o.ale_force && !pins_o.ale_level
  ) else $error("Strobes not driven low in power-down.");

  chk_wdt_ends: assert property (
    wdt_reset |=> in_run ##1 !pins_o.halt
  ) else $error("Watchdog reset did not end the low-power mode.");

  chk_baud_double: assert property (
    (baud_doubler_r && t1_baud_src && uart_mode == 2'b00) |=> !baud_x2
  ) else $error("Baud doubled in serial mode 0.");

endmodule : ipc_ctrl

// >>> rtl/ipc_pkg.sv
// Constants, types and carriers for the interrupt and power mode block.
package ipc_pkg;

  // ==========================================================
  // Register indices and byte addresses
  // ==========================================================
  localparam logic [7:0] IPC_IDX_POWER_MODE_CONTROL = 8'h87;
  localparam logic [7:0] IPC_IDX_IE = 8'hA8;
  localparam logic [7:0] IPC_IDX_IP = 8'hB8;
  localparam logic [7:0] IPC_IDX_STAT = 8'hC0;
  localparam logic [7:0] IPC_IDX_PEND = 8'hC1;
  localparam logic [31:0] IPC_ADR_POWER_MODE_CONTROL = {22'h000000, IPC_IDX_POWER_MODE_CONTROL, 2'b00};
  localparam logic [31:0] IPC_ADR_IE = {22'h000000, IPC_IDX_IE, 2'b00};
  localparam logic [31:0] IPC_ADR_IP = {22'h000000, IPC_IDX_IP, 2'b00};
  localparam logic [31:0] IPC_ADR_STAT = {22'h000000, IPC_IDX_STAT, 2'b00};
  localparam logic [31:0] IPC_ADR_PEND = {22'h000000, IPC_IDX_PEND, 2'b00};

  // ==========================================================
  // Field positions and values after reset
  // ==========================================================
  localparam int IPC_NSRC = 7;
  localparam int IPC_IE_GATE = 7;
  localparam int IPC_POWER_MODE_CONTROL_BAUD_DOUBLER = 7;
  localparam int IPC_POWER_MODE_CONTROL_GF1 = 3;
  localparam int IPC_POWER_MODE_CONTROL_GF0 = 2;
  localparam int IPC_POWER_MODE_CONTROL_PD = 1;
  localparam int IPC_POWER_MODE_CONTROL_IDL = 0;
  localparam int IPC_SRC_EXT0 = 0;
  localparam int IPC_SRC_EXT1 = 2;
  localparam logic [7:0] IPC_IE_RST = 8'h00;
  localparam logic [6:0] IPC_IP_RST = 7'h00;
  localparam logic IPC_BAUD_DOUBLER_RST = 1'b0;
  localparam logic [1:0] IPC_GF_RST = 2'h0;
  localparam logic [6:0] IPC_WAKE_MASK = 7'h05;

  // ==========================================================
  // Fixed order within a level and vector addresses
  // ==========================================================
  localparam logic [2:0] IPC_ORDER_BIT [IPC_NSRC] =
    '{3'h0, 3'h5, 3'h6, 3'h1, 3'h2, 3'h3, 3'h4};
  localparam logic [15:0] IPC_VEC [IPC_NSRC] =
    '{16'h0003, 16'h002B, 16'h0053, 16'h000B, 16'h0013, 16'h001B,
      16'h0023};

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {IPC_RUN, IPC_IDLE, IPC_PDOWN} ipc_mode_t;

  typedef struct packed {
    logic valid;
    logic level;
    logic [2:0] num;
    logic [15:0] vector;
  } ipc_irq_t;

  typedef struct packed {
    logic halt;
    logic osc_stop;
    logic ale_force;
    logic ale_level;
    logic port0_float;
    logic port2_addr;
    logic port2_sfr;
  } ipc_pins_t;

endpackage : ipc_pkg

// >>> rtl/ipc_pick.sv
// Fixed-order picker among the requests of one priority level.
`timescale 1ns/1ps
module ipc_pick #(
  parameter int N = ipc_pkg::IPC_NSRC
) (
  input logic [N-1:0] req,
  output logic valid,
  output logic [2:0] num
);
  import ipc_pkg::*;

  // ==========================================================
  // Elaboration check
  // ==========================================================
  if (N != IPC_NSRC) begin : g_bad_n
    $error("ipc_pick: the order table serves seven sources only.");
  end

  // ==========================================================
  // Search from lowest to highest rank, the last hit wins
  // ==========================================================
  always_comb begin
    valid = 1'b0;
    num = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[IPC_ORDER_BIT[i]]) begin
        valid = 1'b1;
        num = 3'(i);
      end
    end
  end

endmodule : ipc_pick

// >>> dv/ipc_ctrl_test.sv
// Self-checking bench for the interrupt and power mode block.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  bad_count++; $display("mismatch t=%0t got=%h exp=%h", $time, a, e); \
  end end
module ipc_ctrl_test;
  import ipc_pkg::*;
  // ==========================================================
  // Signals and design instance
  // ==========================================================
  logic hclk = 1'b0;
  logic hresetn = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [6:0] src_req = 7'h00;
  logic wdt_reset = 1'b0;
  logic ext_mem = 1'b0;
  logic t1_baud_src = 1'b0;
  logic [1:0] uart_mode = 2'h0;
  logic core_ack = 1'b0;
  logic core_return_from_interrupt = 1'b0;
  ipc_irq_t irq_o;
  ipc_pins_t pins_o;
  logic baud_x2;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] rd;
  ipc_ctrl u_ipc_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_req(src_req),
    .wdt_reset(wdt_reset), .ext_mem(ext_mem), .t1_baud_src(t1_baud_src),
    .uart_mode(uart_mode), .core_ack(core_ack), .core_return_from_interrupt(core_return_from_interrupt),
    .irq_o(irq_o), .pins_o(pins_o), .baud_x2(baud_x2));
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  // ==========================================================
  // Bus and core handshake tasks
  // ==========================================================
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    `CHK(hresp, 1'b0)
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, {24'h000000, d}, r);
  endtask : wr
  task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0, rd);
    `CHK(rd, {24'h000000, e})
  endtask : rd_chk
  task automatic wait_irq(input logic [15:0] v, input logic lvl);
    int n;
    n = 0;
    while (irq_o.valid !== 1'b1 && n < 10) begin
      @(posedge hclk);
      n++;
    end
    `CHK(irq_o.valid, 1'b1)
    `CHK(irq_o.vector, v)
    `CHK(irq_o.level, lvl)
  endtask : wait_irq
  task automatic no_irq();
    repeat (4) @(posedge hclk);
    `CHK(irq_o.valid, 1'b0)
  endtask : no_irq
  task automatic ack(input logic [6:0] drop);
    @(posedge hclk);
    core_ack <= 1'b1; src_req <= src_req & ~drop;
    @(posedge hclk);
    core_ack <= 1'b0;
  endtask : ack
  task automatic return_from_interrupt();
    @(posedge hclk);
    core_return_from_interrupt <= 1'b1;
    @(posedge hclk);
    core_return_from_interrupt <= 1'b0;
  endtask : return_from_interrupt
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic regs_test();
    rd_chk(IPC_ADR_POWER_MODE_CONTROL, 8'h00);
    rd_chk(IPC_ADR_IE, 8'h00);
    rd_chk(IPC_ADR_IP, 8'h00);
    wr(32'h0000_0100, 8'hFF);
    rd_chk(32'h0000_0100, 8'h00);
    wr(IPC_ADR_IP, 8'hFF);
    rd_chk(IPC_ADR_IP, 8'h7F);
    wr(IPC_ADR_IE, 8'h5A);
    rd_chk(IPC_ADR_IE, 8'h5A);
    wr(IPC_ADR_POWER_MODE_CONTROL, 8'h7C);
    rd_chk(IPC_ADR_POWER_MODE_CONTROL, 8'h0C);
    wr(IPC_ADR_POWER_MODE_CONTROL, 8'hF0);
    rd_chk(IPC_ADR_POWER_MODE_CONTROL, 8'h80);
    for (int t = 0; t < 2; t++) begin
      for (int m = 0; m < 4; m++) begin
        @(posedge hclk);
        t1_baud_src <= t[0]; uart_mode <= m[1:0];
        repeat (2) @(posedge hclk);
        `CHK(baud_x2, t[0] && m != 0)
      end
    end
    wr(IPC_ADR_POWER_MODE_CONTROL, 8'h00);
    repeat (2) @(posedge hclk);
    `CHK(baud_x2, 1'b0)
    wr(IPC_ADR_IP, 8'h00);
  endtask : regs_test
  task automatic gate_test();
    wr(IPC_ADR_IE, 8'h01);
    @(posedge hclk);
    src_req <= 7'h01;
    no_irq();
    wr(IPC_ADR_IE, 8'h81);
    wait_irq(16'h0003, 1'b0);
    ack(7'h01);
    return_from_interrupt();
  endtask : gate_test
  task automatic order_test();
    logic [2:0] bitpos [7] = '{3'h0, 3'h5, 3'h6, 3'h1, 3'h2, 3'h3, 3'h4};
    logic [15:0] vec [7] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B,
                             16'h0013, 16'h001B, 16'h0023};
    wr(IPC_ADR_IE, 8'hFF);
    @(posedge hclk);
    src_req <= 7'h7F;
    for (int k = 0; k < 7; k++) begin
      wait_irq(vec[k], 1'b0);
      `CHK(irq_o.num, k[2:0])
      ack(7'h01 << bitpos[k]);
      return_from_interrupt();
    end
  endtask : order_test
  task automatic preempt_test();
    wr(IPC_ADR_IP, 8'h08);
    @(posedge hclk);
    src_req <= 7'h10;
    wait_irq(16'h0023, 1'b0);
    ack(7'h10);
    @(posedge hclk);
    src_req <= 7'h02;
    no_irq();
    rd_chk(IPC_ADR_PEND, 8'h02);
    @(posedge hclk);
    src_req <= 7'h0A;
    wait_irq(16'h001B, 1'b1);
    ack(7'h08);
    return_from_interrupt();
    no_irq();
    return_from_interrupt();
    wait_irq(16'h000B, 1'b0);
    ack(7'h02);
    return_from_interrupt();
    wr(IPC_ADR_IP, 8'h00);
  endtask : preempt_test
  task automatic mode_test();
    wr(IPC_ADR_IE, 8'h86);
    @(posedge hclk);
    ext_mem <= 1'b1;
    wr(IPC_ADR_POWER_MODE_CONTROL, 8'h05);
    repeat (3) @(posedge hclk);
    `CHK(pins_o, 7'b1011110)
    rd_chk(IPC_ADR_STAT, 8'h61);
    @(posedge hclk);
    src_req <= 7'h02;
    wait_irq(16'h000B, 1'b0);
    repeat (2) @(posedge hclk);
    `CHK(pins_o, 7'h00)
    rd_chk(IPC_ADR_POWER_MODE_CONTROL, 8'h04);
    ack(7'h02);
    return_from_interrupt();
    wr(IPC_ADR_POWER_MODE_CONTROL, 8'h03);
    repeat (3) @(posedge hclk);
    `CHK(pins_o, 7'b1110101)
    rd_chk(IPC_ADR_POWER_MODE_CONTROL, 8'h02);
    @(posedge hclk);
    src_req <= 7'h02;
    no_irq();
    @(posedge hclk);
    src_req <= 7'h06;
    wait_irq(16'h0013, 1'b0);
    repeat (2) @(posedge hclk);
    `CHK(pins_o.osc_stop, 1'b0)
    ack(7'h06);
    return_from_interrupt();
    wr(IPC_ADR_POWER_MODE_CONTROL, 8'h01);
    @(posedge hclk);
    wdt_reset <= 1'b1;
    @(posedge hclk);
    wdt_reset <= 1'b0;
    repeat (3) @(posedge hclk);
    `CHK(pins_o, 7'h00)
    rd_chk(IPC_ADR_IE, 8'h00);
  endtask : mode_test
  task automatic complete_run();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  initial begin
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    regs_test();
    gate_test();
    order_test();
    preempt_test();
    mode_test();
    complete_run();
  end
endmodule : ipc_ctrl_test
